/* File: inc/bdp_pkg.sv */
/*
 * Shared constants of the bias-drive / power-up link: device register map,
 * field positions, reset values, host register map and sequence timing.
 * Assumes one 125 MHz clock shared by both ends.
 */
package bdp_pkg;
   // device register addresses
   localparam logic [7:0] DEV_FIRST_CFG_ADDR = 8'h01;
   localparam logic [7:0] DEV_BIAS_PWR_ADDR = 8'h03;
   localparam logic [7:0] DEV_ELEC_OFF_ADDR = 8'h04;
   localparam logic [7:0] DEV_CALIB_BIAS_ADDR = 8'h0A;
   localparam logic [7:0] DEV_CHECK_CTRL_ADDR = 8'h0C;
   localparam logic [7:0] DEV_STATUS_ADDR = 8'h0D;
   // device field positions
   localparam int BIAS_AMP_POWER_BIT = 2;
   localparam int BIAS_REF_SEL_BIT = 1;
   localparam int CALIB_ON_BIT = 7;
   localparam int THRESH_MSB = 7;
   localparam int THRESH_LSB = 5;
   localparam int CHECK_EN_BIT = 0;
   localparam int STAT_CMP_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;
   localparam int STAT_CFG_DONE_BIT = 2;
   localparam int STAT_AMP_ON_BIT = 3;
   // device reset values and calibration write mask
   localparam logic [7:0] FIRST_CFG_RST = 8'h00;
   localparam logic [7:0] BIAS_PWR_RST = 8'h00;
   localparam logic [7:0] ELEC_OFF_RST = 8'h00;
   localparam logic [7:0] CALIB_BIAS_RST = 8'h00;
   localparam logic [7:0] CALIB_BIAS_MASK = 8'h82;
   localparam logic [7:0] CHECK_CTRL_RST = 8'h00;
   localparam logic [3:0] THRESH_BASE = 4'h8;
   // host register map (user side)
   localparam logic [1:0] HOST_CTRL_ADDR = 2'h0;
   localparam logic [1:0] HOST_STATUS_ADDR = 2'h1;
   localparam logic [1:0] HOST_DEVWR_ADDR = 2'h2;
   localparam logic [1:0] HOST_DEVRD_ADDR = 2'h3;
   localparam logic [15:0] HOST_CTRL_RST = 16'h0000;
   localparam int CTRL_PRIMARY_BIT = 0;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int MOD_PERIOD_NS = 64;
   localparam int MOD_HALF_CYCLES = MOD_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int POR_MOD_PERIODS = 2048;
   localparam int RST_MOD_PERIODS = 1;
   localparam int RST_HOLD_TICKS = RST_MOD_PERIODS + 1;
   localparam int POR_CYCLES = POR_MOD_PERIODS * MOD_PERIOD_NS / CLK_PERIOD_NS;
   // host sequencer states
   typedef enum logic [2:0] {
      BDP_OFF = 3'b000,
      BDP_CLKWAIT = 3'b001,
      BDP_RST = 3'b010,
      BDP_CFG = 3'b011,
      BDP_BIAS = 3'b100,
      BDP_READY = 3'b101
   } bdp_state_t;
endpackage : bdp_pkg

/* File: inc/bdp_link_if.sv */
/*
 * Pins between host sequencer and device: modulator clock, reset,
 * parallel register write/read port.
 * Assumes both ends clocked by the same mclk_in.
 */
interface bdp_link_if;
   logic mod_clk;
   logic dev_rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;

   modport host (
      output mod_clk, dev_rst_n, reg_addr, reg_wdata, reg_wr, reg_rd,
      input reg_rdata
   );
   modport dev (
      input mod_clk, dev_rst_n, reg_addr, reg_wdata, reg_wr, reg_rd,
      output reg_rdata
   );
endinterface : bdp_link_if

/* File: src/bdp_device.sv */
/*
 * Device end: register file reached over the link, pin reset taken on
 * rising modulator clock edges, body-bias drive controls and the power-up
 * electrode-off check on the bias electrode.
 * Assumes link pins synchronous to mclk_in; analog level arrives digitised.
 */
module bdp_device (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // link
   bdp_link_if.dev link,
   // analog side
   input wire logic [3:0] bias_level_in,
   output logic bias_amp_on_out,
   output logic bias_ref_internal_select_out,
   output logic sink_enable_out,
   output logic [3:0] comp_threshold_out,
   output logic electrode_off_out,
   output logic calib_on_out,
   output logic conv_enable_out
);

   // decode of the threshold field to a comparator level
   function automatic logic [3:0] thresh_level(input logic [7:0] cfg);
      thresh_level = bdp_pkg::THRESH_BASE + {1'b0, cfg[bdp_pkg::THRESH_MSB:bdp_pkg::THRESH_LSB]};
   endfunction : thresh_level

   logic mod_clk_prev_q;
   logic [7:0] first_cfg_q;
   logic [7:0] first_cfg_d;
   logic [7:0] bias_pwr_q;
   logic [7:0] bias_pwr_d;
   logic [7:0] elec_off_q;
   logic [7:0] elec_off_d;
   logic [7:0] calib_q;
   logic [7:0] calib_d;
   logic [7:0] check_q;
   logic [7:0] check_d;
   logic cfg_done_q;
   logic cfg_done_d;
   logic cmp_q;
   logic latch_q;
   logic latch_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic amp_on_q;
   logic ref_int_q;
   logic sink_q;
   logic [3:0] thr_q;
   logic calib_on_q;

   wire mod_tick = link.mod_clk & ~mod_clk_prev_q;
   // reset pin only acts on a modulator edge, so a pulse shorter than a
   // period may be missed
   wire pin_reset = mod_tick & ~link.dev_rst_n;
   wire wr_ok = link.reg_wr & link.dev_rst_n;
   wire wr_first = wr_ok & (link.reg_addr == bdp_pkg::DEV_FIRST_CFG_ADDR);
   wire wr_pwr = wr_ok & (link.reg_addr == bdp_pkg::DEV_BIAS_PWR_ADDR);
   wire wr_eoff = wr_ok & (link.reg_addr == bdp_pkg::DEV_ELEC_OFF_ADDR);
   wire wr_calib = wr_ok & (link.reg_addr == bdp_pkg::DEV_CALIB_BIAS_ADDR);
   wire wr_check = wr_ok & (link.reg_addr == bdp_pkg::DEV_CHECK_CTRL_ADDR);
   wire amp_on = bias_pwr_q[bdp_pkg::BIAS_AMP_POWER_BIT];
   wire check_active = check_q[bdp_pkg::CHECK_EN_BIT] & ~amp_on;
   wire [3:0] thr_level = thresh_level(elec_off_q);
   wire cmp_now = bias_level_in >= thr_level;
   wire [7:0] status_word = {4'h0, amp_on, cfg_done_q, latch_q, cmp_q};

   always_comb begin
      first_cfg_d = first_cfg_q;
      bias_pwr_d = bias_pwr_q;
      elec_off_d = elec_off_q;
      calib_d = calib_q;
      check_d = check_q;
      cfg_done_d = cfg_done_q;
      if (pin_reset) begin
         first_cfg_d = bdp_pkg::FIRST_CFG_RST;
         bias_pwr_d = bdp_pkg::BIAS_PWR_RST;
         elec_off_d = bdp_pkg::ELEC_OFF_RST;
         calib_d = bdp_pkg::CALIB_BIAS_RST;
         check_d = bdp_pkg::CHECK_CTRL_RST;
         cfg_done_d = 1'b0;
      end else begin
         if (wr_first) begin
            first_cfg_d = link.reg_wdata;
            cfg_done_d = 1'b1;
         end
         if (wr_pwr) begin
            bias_pwr_d = link.reg_wdata;
         end
         if (wr_eoff) begin
            elec_off_d = link.reg_wdata;
         end
         if (wr_calib) begin
            // must-be-zero bits are dropped on write
            calib_d = link.reg_wdata & bdp_pkg::CALIB_BIAS_MASK;
         end
         if (wr_check) begin
            check_d = link.reg_wdata;
         end
      end
   end

   // sticky electrode-off result: a new hit wins over the clearing write
   always_comb begin
      latch_d = latch_q;
      if (pin_reset) begin
         latch_d = 1'b0;
      end else if (check_active & cmp_q) begin
         latch_d = 1'b1;
      end else if (wr_check & ~link.reg_wdata[bdp_pkg::CHECK_EN_BIT]) begin
         latch_d = 1'b0;
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (link.reg_rd) begin
         unique case (link.reg_addr)
            bdp_pkg::DEV_FIRST_CFG_ADDR: rdata_d = first_cfg_q;
            bdp_pkg::DEV_BIAS_PWR_ADDR: rdata_d = bias_pwr_q;
            bdp_pkg::DEV_ELEC_OFF_ADDR: rdata_d = elec_off_q;
            bdp_pkg::DEV_CALIB_BIAS_ADDR: rdata_d = calib_q;
            bdp_pkg::DEV_CHECK_CTRL_ADDR: rdata_d = check_q;
            bdp_pkg::DEV_STATUS_ADDR: rdata_d = status_word;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         mod_clk_prev_q <= 1'b0;
         first_cfg_q <= bdp_pkg::FIRST_CFG_RST;
         bias_pwr_q <= bdp_pkg::BIAS_PWR_RST;
         elec_off_q <= bdp_pkg::ELEC_OFF_RST;
         calib_q <= bdp_pkg::CALIB_BIAS_RST;
         check_q <= bdp_pkg::CHECK_CTRL_RST;
         cfg_done_q <= 1'b0;
         latch_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         mod_clk_prev_q <= link.mod_clk;
         first_cfg_q <= first_cfg_d;
         bias_pwr_q <= bias_pwr_d;
         elec_off_q <= elec_off_d;
         calib_q <= calib_d;
         check_q <= check_d;
         cfg_done_q <= cfg_done_d;
         latch_q <= latch_d;
         rdata_q <= rdata_d;
      end
   end

   // analog-facing controls, all registered
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cmp_q <= 1'b0;
         amp_on_q <= 1'b0;
         ref_int_q <= 1'b0;
         sink_q <= 1'b0;
         thr_q <= bdp_pkg::THRESH_BASE;
         calib_on_q <= 1'b0;
      end else begin
         cmp_q <= cmp_now;
         amp_on_q <= amp_on;
         ref_int_q <= calib_q[bdp_pkg::BIAS_REF_SEL_BIT];
         sink_q <= check_active;
         thr_q <= thr_level;
         calib_on_q <= calib_q[bdp_pkg::CALIB_ON_BIT];
      end
   end

   assign link.reg_rdata = rdata_q;
   assign bias_amp_on_out = amp_on_q;
   // low selects the external divider, high the internal midpoint
   assign bias_ref_internal_select_out = ref_int_q;
   // sink forced off whenever the amplifier drives the electrode
   assign sink_enable_out = sink_q;
   assign comp_threshold_out = thr_q;
   // comparator is the only view of the amplifier output node
   assign electrode_off_out = cmp_q;
   assign calib_on_out = calib_on_q;
   // conversions meaningful only once the first configuration is written
   assign conv_enable_out = cfg_done_q;

endmodule : bdp_device

/* File: src/bdp_host.sv */
/*
 * Host end: power-up sequencer (inputs low, clock start, wait, reset
 * pulse, first configuration, bias amplifier power) and user register port.
 * Assumes supplies_stable_in synchronous to mclk_in.
 */
module bdp_host #(
   parameter int POR_TICKS = bdp_pkg::POR_MOD_PERIODS
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // supply monitor
   input wire logic supplies_stable_in,
   // user register port
   input wire logic [1:0] usr_addr_in,
   input wire logic [15:0] usr_wdata_in,
   input wire logic usr_wr_in,
   input wire logic usr_rd_in,
   output logic [15:0] usr_rdata_out,
   // link
   bdp_link_if.host link
);

   bdp_pkg::bdp_state_t state_q;
   bdp_pkg::bdp_state_t state_d;
   logic [2:0] div_q;
   logic mod_clk_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic rst_n_q;
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic [7:0] wdata_q;
   logic [7:0] wdata_d;
   logic wr_q;
   logic wr_d;
   logic rd_q;
   logic rd_d;
   logic rd_wait_q;
   logic [7:0] rd_last_q;
   logic [15:0] ctrl_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   wire clk_run = state_q != bdp_pkg::BDP_OFF;
   wire div_wrap = div_q == 3'(bdp_pkg::MOD_HALF_CYCLES - 1);
   wire tick = clk_run & div_wrap & ~mod_clk_q;
   wire ready = state_q == bdp_pkg::BDP_READY;
   wire usr_devwr = usr_wr_in & (usr_addr_in == bdp_pkg::HOST_DEVWR_ADDR) & ready;
   wire usr_devrd = usr_wr_in & (usr_addr_in == bdp_pkg::HOST_DEVRD_ADDR) & ready;
   wire usr_ctrl = usr_wr_in & (usr_addr_in == bdp_pkg::HOST_CTRL_ADDR);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = 8'h00;
      wdata_d = 8'h00;
      wr_d = 1'b0;
      rd_d = 1'b0;
      unique case (state_q)
         bdp_pkg::BDP_OFF: begin
            cnt_d = 16'h0000;
            if (supplies_stable_in) begin
               state_d = bdp_pkg::BDP_CLKWAIT;
            end
         end
         bdp_pkg::BDP_CLKWAIT: begin
            if (tick) begin
               cnt_d = cnt_q + 16'h0001;
               if (cnt_q == 16'(POR_TICKS - 1)) begin
                  state_d = bdp_pkg::BDP_RST;
                  cnt_d = 16'h0000;
               end
            end
         end
         bdp_pkg::BDP_RST: begin
            if (tick) begin
               cnt_d = cnt_q + 16'h0001;
               if (cnt_q == 16'(bdp_pkg::RST_HOLD_TICKS - 1)) begin
                  state_d = bdp_pkg::BDP_CFG;
               end
            end
         end
         bdp_pkg::BDP_CFG: begin
            addr_d = bdp_pkg::DEV_FIRST_CFG_ADDR;
            wdata_d = ctrl_q[15:8];
            wr_d = 1'b1;
            state_d = bdp_pkg::BDP_BIAS;
         end
         bdp_pkg::BDP_BIAS: begin
            addr_d = bdp_pkg::DEV_BIAS_PWR_ADDR;
            // only the chain's primary keeps its bias amplifier on
            wdata_d = 8'(ctrl_q[bdp_pkg::CTRL_PRIMARY_BIT]) << bdp_pkg::BIAS_AMP_POWER_BIT;
            wr_d = 1'b1;
            state_d = bdp_pkg::BDP_READY;
         end
         bdp_pkg::BDP_READY: begin
            if (usr_devwr) begin
               addr_d = usr_wdata_in[15:8];
               wdata_d = usr_wdata_in[7:0];
               wr_d = 1'b1;
            end else if (usr_devrd) begin
               addr_d = usr_wdata_in[15:8];
               rd_d = 1'b1;
            end
         end
         default: state_d = bdp_pkg::BDP_OFF;
      endcase
      if (!supplies_stable_in) begin
         state_d = bdp_pkg::BDP_OFF;
      end
   end

   always_comb begin
      rdata_d = 16'h0000;
      if (usr_rd_in) begin
         unique case (usr_addr_in)
            bdp_pkg::HOST_CTRL_ADDR: rdata_d = ctrl_q;
            bdp_pkg::HOST_STATUS_ADDR: rdata_d = {12'h000, ready, state_q};
            bdp_pkg::HOST_DEVRD_ADDR: rdata_d = {7'h00, rd_wait_q, rd_last_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= bdp_pkg::BDP_OFF;
         cnt_q <= 16'h0000;
         div_q <= 3'h0;
         mod_clk_q <= 1'b0;
         rst_n_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         div_q <= (!clk_run || div_wrap) ? 3'h0 : div_q + 3'h1;
         mod_clk_q <= clk_run & (div_wrap ? ~mod_clk_q : mod_clk_q);
         rst_n_q <= (state_d != bdp_pkg::BDP_OFF) && (state_d != bdp_pkg::BDP_CLKWAIT)
                    && (state_d != bdp_pkg::BDP_RST);
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= bdp_pkg::HOST_CTRL_RST;
         rd_wait_q <= 1'b0;
         rd_last_q <= 8'h00;
         rdata_q <= 16'h0000;
      end else begin
         if (usr_ctrl) begin
            ctrl_q <= usr_wdata_in;
         end
         rd_wait_q <= rd_q;
         if (rd_wait_q) begin
            rd_last_q <= link.reg_rdata;
         end
         rdata_q <= rdata_d;
      end
   end

   assign link.mod_clk = mod_clk_q;
   assign link.dev_rst_n = rst_n_q;
   assign link.reg_addr = addr_q;
   assign link.reg_wdata = wdata_q;
   assign link.reg_wr = wr_q;
   assign link.reg_rd = rd_q;
   assign usr_rdata_out = rdata_q;

endmodule : bdp_host

/* File: testbench/bdp_link_sva.sv */
/*
 * Concurrent checks on the host-to-device link: modulator clock shape,
 * reset pulse width, access order after reset and read/write strobes never together.
 * Assumes all link signals are synchronous to mclk_in.
 */
module bdp_link_sva #(
   parameter int POR_TICKS = bdp_pkg::POR_MOD_PERIODS
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // link
   input wire logic mod_clk,
   input wire logic dev_rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mod_q;
   logic mod_seen_q;
   logic cfg_seen_q;
   logic [15:0] rise_cnt_q;
   logic [15:0] rise_now;
   logic cfg_wr;
   // count includes a rise in the current cycle, so either release timing passes
   assign rise_now = rise_cnt_q + {15'h0000, mod_clk & ~mod_q};
   assign cfg_wr = reg_wr && (reg_addr == bdp_pkg::DEV_FIRST_CFG_ADDR);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         mod_q <= 1'b0;
         mod_seen_q <= 1'b0;
         cfg_seen_q <= 1'b0;
         rise_cnt_q <= 16'h0000;
      end else begin
         mod_q <= mod_clk;
         mod_seen_q <= mod_seen_q | mod_clk;
         cfg_seen_q <= dev_rst_n & (cfg_seen_q | cfg_wr);
         rise_cnt_q <= dev_rst_n ? 16'h0000 : rise_now;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   property p_one_strobe; !(reg_wr && reg_rd); endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("link read and write strobes together");
   // configuration and bias writes run back to back, so the write strobe may stand two cycles
   property p_cfg_after_rst;
      $rose(dev_rst_n) |-> !reg_wr ##1 (reg_wr && reg_addr == bdp_pkg::DEV_FIRST_CFG_ADDR);
   endproperty
   a_cfg_after_rst: assert property (p_cfg_after_rst) else $error("config write not right after reset");
   property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
   property p_mod_high; $rose(mod_clk) |-> mod_clk [*4] ##1 !mod_clk; endproperty
   a_mod_high: assert property (p_mod_high) else $error("modulator clock high phase wrong");
   property p_mod_low; $fell(mod_clk) |-> !mod_clk [*4] ##1 mod_clk; endproperty
   a_mod_low: assert property (p_mod_low) else $error("modulator clock low phase wrong");
   property p_quiet_before_clk; !mod_seen_q |-> !dev_rst_n && !reg_wr && !reg_rd; endproperty
   a_quiet_before_clk: assert property (p_quiet_before_clk) else $error("pins active before clock");
   property p_rst_width; $rose(dev_rst_n) |-> rise_now == POR_TICKS + bdp_pkg::RST_HOLD_TICKS; endproperty
   a_rst_width: assert property (p_rst_width) else $error("reset released after wrong count");
   property p_no_access_in_rst; !dev_rst_n |-> !reg_wr && !reg_rd; endproperty
   a_no_access_in_rst: assert property (p_no_access_in_rst) else $error("access during reset");
   property p_first_cfg; reg_wr && !cfg_seen_q |-> reg_addr == bdp_pkg::DEV_FIRST_CFG_ADDR; endproperty
   a_first_cfg: assert property (p_first_cfg) else $error("first write not configuration");
   property p_bias_wr;
      $rose(cfg_seen_q) |-> ##[0:8] (reg_wr && reg_addr == bdp_pkg::DEV_BIAS_PWR_ADDR && (reg_wdata & 8'hFB) == 8'h00);
   endproperty
   a_bias_wr: assert property (p_bias_wr) else $error("bias power write missing");

   c_release: cover property ($rose(dev_rst_n));
   c_cfg: cover property ($rose(cfg_seen_q));
   c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : bdp_link_sva

/* File: testbench/bdp_tb.sv */
/*
 * Self-checking bench: host and device joined by the link interface,
 * power-up, device register traffic, threshold and bias checks.
 * Assumes one 125 MHz clock; short power-on count for run time.
 */
module bdp_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR_TICKS = 4;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic supplies_stable_in = 1'b0;
   logic [1:0] usr_addr_in = 2'h0;
   logic [15:0] usr_wdata_in = 16'h0000;
   logic usr_wr_in = 1'b0;
   logic usr_rd_in = 1'b0;
   logic [15:0] usr_rdata_out;
   logic [3:0] bias_level_in = 4'h0;
   logic amp_on, ref_int, sink_on, eoff, calib_on, conv_en;
   logic [3:0] thr;
   logic [15:0] r;
   int err_count = 0;
   int check_count = 0;

   always #4 mclk_in = ~mclk_in;

   bdp_link_if link ();
   bdp_host #(.POR_TICKS(POR_TICKS)) bdp_host_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .supplies_stable_in(supplies_stable_in), .usr_addr_in(usr_addr_in), .usr_wdata_in(usr_wdata_in),
      .usr_wr_in(usr_wr_in), .usr_rd_in(usr_rd_in), .usr_rdata_out(usr_rdata_out), .link(link));
   bdp_device bdp_device_inst (.mclk_in(mclk_in), .rst_in(rst_in), .link(link), .bias_level_in(bias_level_in),
      .bias_amp_on_out(amp_on), .bias_ref_internal_select_out(ref_int), .sink_enable_out(sink_on),
      .comp_threshold_out(thr), .electrode_off_out(eoff), .calib_on_out(calib_on), .conv_enable_out(conv_en));
   bdp_link_sva #(.POR_TICKS(POR_TICKS)) bdp_link_sva_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .mod_clk(link.mod_clk), .dev_rst_n(link.dev_rst_n), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
      .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic usr_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      usr_addr_in <= a;
      usr_wdata_in <= d;
      usr_wr_in <= 1'b1;
      @(posedge mclk_in);
      usr_wr_in <= 1'b0;
   endtask : usr_wr

   task automatic usr_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge mclk_in);
      usr_addr_in <= a;
      usr_rd_in <= 1'b1;
      @(posedge mclk_in);
      usr_rd_in <= 1'b0;
      #1 d = usr_rdata_out;
   endtask : usr_rd

   // outputs lag the link write by two cycles, four leaves margin
   task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
      usr_wr(bdp_pkg::HOST_DEVWR_ADDR, {a, d});
      repeat (4) @(posedge mclk_in);
      #1;
   endtask : dev_wr

   task automatic dev_rd(input logic [7:0] a, output logic [15:0] d);
      usr_wr(bdp_pkg::HOST_DEVRD_ADDR, {a, 8'h00});
      repeat (4) @(posedge mclk_in);
      usr_rd(bdp_pkg::HOST_DEVRD_ADDR, d);
   endtask : dev_rd

   task automatic t_idle();
      repeat (20) @(posedge mclk_in);
      usr_rd(bdp_pkg::HOST_CTRL_ADDR, r);
      check("ctrl reset", r, bdp_pkg::HOST_CTRL_RST);
      check("mod clock idle", link.mod_clk, 1'b0);
      check("dev reset idle", link.dev_rst_n, 1'b0);
      check("threshold reset", thr, bdp_pkg::THRESH_BASE);
      check("ref default", ref_int, 1'b0);
      check("conv before cfg", conv_en, 1'b0);
      usr_wr(bdp_pkg::HOST_CTRL_ADDR, 16'h5A01);
   endtask : t_idle

   // raise supplies and poll until ready; the bias write lands two cycles later
   task automatic wait_ready();
      int i;
      @(posedge mclk_in);
      supplies_stable_in <= 1'b1;
      r = 16'h0000;
      for (i = 0; i < 300 && r[3] !== 1'b1; i++) usr_rd(bdp_pkg::HOST_STATUS_ADDR, r);
      check("status ready", r, {12'h000, 1'b1, bdp_pkg::BDP_READY});
      repeat (3) @(posedge mclk_in);
      #1;
   endtask : wait_ready

   task automatic t_powerup();
      wait_ready();
      check("conv enabled", conv_en, 1'b1);
      check("primary amp on", amp_on, 1'b1);
      dev_rd(bdp_pkg::DEV_FIRST_CFG_ADDR, r);
      check("first cfg", r, 16'h005A);
      dev_rd(bdp_pkg::DEV_BIAS_PWR_ADDR, r);
      check("bias power reg", r, 16'h0004);
   endtask : t_powerup

   // mid-run reset, then a chain member that is not the primary
   task automatic t_secondary();
      @(posedge mclk_in);
      rst_in <= 1'b1;
      supplies_stable_in <= 1'b0;
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      usr_wr(bdp_pkg::HOST_CTRL_ADDR, 16'h3300);
      #1 check("conv after reset", conv_en, 1'b0);
      wait_ready();
      check("secondary amp off", amp_on, 1'b0);
      check("conv again", conv_en, 1'b1);
      dev_rd(bdp_pkg::DEV_BIAS_PWR_ADDR, r);
      check("secondary bias reg", r, 16'h0000);
      dev_rd(bdp_pkg::DEV_FIRST_CFG_ADDR, r);
      check("first cfg again", r, 16'h0033);
   endtask : t_secondary

   task automatic t_ref_sel();
      dev_wr(bdp_pkg::DEV_CALIB_BIAS_ADDR, 8'hFF);
      check("ref internal", ref_int, 1'b1);
      check("calib on", calib_on, 1'b1);
      dev_rd(bdp_pkg::DEV_CALIB_BIAS_ADDR, r);
      check("calib masked", r, {8'h00, bdp_pkg::CALIB_BIAS_MASK});
      dev_wr(bdp_pkg::DEV_CALIB_BIAS_ADDR, 8'h00);
      check("ref external", ref_int, 1'b0);
      check("calib off", calib_on, 1'b0);
      dev_rd(8'h20, r);
      check("unmapped read", r, 16'h0000);
   endtask : t_ref_sel

   task automatic t_thresh();
      for (int f = 0; f < 8; f++) begin
         dev_wr(bdp_pkg::DEV_ELEC_OFF_ADDR, 8'(f << 5));
         check("threshold", thr, 16'(bdp_pkg::THRESH_BASE + f));
      end
   endtask : t_thresh

   // amp on: sink stays off and comparator still reports; amp off: sink works
   task automatic t_check();
      dev_wr(bdp_pkg::DEV_ELEC_OFF_ADDR, 8'h00);
      dev_wr(bdp_pkg::DEV_CHECK_CTRL_ADDR, 8'h01);
      @(posedge mclk_in);
      bias_level_in <= 4'hC;
      repeat (3) @(posedge mclk_in);
      #1 check("sink amp on", sink_on, 1'b0);
      check("cmp amp on", eoff, 1'b1);
      dev_rd(bdp_pkg::DEV_STATUS_ADDR, r);
      check("status no latch", r, 16'h000D);
      dev_wr(bdp_pkg::DEV_BIAS_PWR_ADDR, 8'h00);
      check("amp off", amp_on, 1'b0);
      check("sink amp off", sink_on, 1'b1);
      dev_rd(bdp_pkg::DEV_STATUS_ADDR, r);
      check("status latched", r, 16'h0007);
      @(posedge mclk_in);
      bias_level_in <= 4'h3;
      repeat (3) @(posedge mclk_in);
      #1 check("cmp below", eoff, 1'b0);
      dev_wr(bdp_pkg::DEV_CHECK_CTRL_ADDR, 8'h00);
      check("sink cleared", sink_on, 1'b0);
      dev_rd(bdp_pkg::DEV_STATUS_ADDR, r);
      check("status cleared", r, 16'h0004);
   endtask : t_check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #200000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_idle();
      t_powerup();
      t_ref_sel();
      t_thresh();
      t_check();
      t_secondary();
      tally_and_finish();
   end
endmodule : bdp_tb
